// ---- design/fbac_pkg.sv ----
/*
  Constants, state codes and register map of the frame buffer
  address counter. Assumes a single 100 MHz system clock.
*/
package fbac_pkg;
  localparam int ADDR_W     = 18;
  localparam int STAGE_W    = 9;
  localparam int SAMPLE_W   = 8;
  localparam int BLANK_LO_W = 4;
  localparam int BLANK_HI_W = 3;
  localparam int BLANK_W    = BLANK_LO_W + BLANK_HI_W;
  localparam int STATE_W    = 4;
  localparam int REG_AW     = 8;
  localparam int REG_DW     = 32;

  // Address counter terminal values and test preset
  localparam logic [ADDR_W-1:0]  FRAME_LAST_ADDR = 18'h3dd3b;
  localparam logic [STAGE_W-1:0] LOW_CARRY_AT    = 9'h1fe;
  localparam logic [ADDR_W-1:0]  PRESET_MASK     = 18'h3dd00;

  // Blank-level run counter
  localparam logic [BLANK_LO_W-1:0] BLANK_CARRY_AT = 4'he;
  localparam logic [BLANK_W-1:0]    BLANK_FOUND_AT = 7'h7f;

  // Register map
  localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] REG_ADDR   = 8'h08;
  localparam logic [REG_AW-1:0] REG_BLANK  = 8'h0c;
  localparam int   CTRL_CAPTURE_BIT = 0;
  localparam logic CTRL_RESET       = 1'b0;
  localparam int   STAT_STATE_LSB   = 0;
  localparam int   STAT_END_BIT     = 4;
  localparam int   STAT_VBLANK_BIT  = 5;

  typedef enum logic [STATE_W-1:0] {
    ST_IDLE      = 4'h1,
    ST_SYNC_WAIT = 4'h2,
    ST_SAMPLE    = 4'h4,
    ST_DISPLAY   = 4'h8
  } fbac_state_t;
endpackage : fbac_pkg

// ---- design/fbac_link_if.sv ----
/*
  Signals shared by the address counter, the blank-level run
  counter and the control state machine. No clock inside.
*/
`timescale 1ns/100ps
`default_nettype none
interface fbac_link_if;
  import fbac_pkg::*;
  logic                addressAdvance;
  logic                vblankFound;
  logic                frameEndFlag;
  logic [STATE_W-1:0]  ctrlStateBits;
  logic [BLANK_W-1:0]  blankCount;
  modport ctrl  (output addressAdvance, output ctrlStateBits,
                 input vblankFound, input frameEndFlag);
  modport blank (output vblankFound, output blankCount);
  modport core  (input addressAdvance, input ctrlStateBits,
                 input vblankFound, input blankCount,
                 output frameEndFlag);
endinterface : fbac_link_if
`default_nettype wire

// ---- design/fbac_blank_run.sv ----
/*
  Blank-level run counter: counts consecutive zero samples.
  Assumes samples are synchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module fbac_blank_run
  import fbac_pkg::*;
(
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                arst_n,
  // Converter samples
  input wire logic [SAMPLE_W-1:0] videoSample,
  // Shared link
  fbac_link_if.blank              lnk
);
  logic [BLANK_LO_W-1:0] blankRunLow_reg;
  logic [BLANK_LO_W-1:0] blankRunLow_next;
  logic [BLANK_HI_W-1:0] blankRunHigh_reg;
  logic [BLANK_HI_W-1:0] blankRunHigh_next;
  logic                  blankLowCarry_reg;
  wire logic             sampleZero;

  assign sampleZero = (videoSample == '0);
  assign blankRunLow_next = sampleZero ?
    BLANK_LO_W'(blankRunLow_reg + 4'h1) : '0;
  assign blankRunHigh_next = !sampleZero ? '0 :
    blankLowCarry_reg ? BLANK_HI_W'(blankRunHigh_reg + 3'h1) :
    blankRunHigh_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      blankRunLow_reg   <= '0;
      blankRunHigh_reg  <= '0;
      blankLowCarry_reg <= 1'b0;
    end else begin
      blankRunLow_reg   <= blankRunLow_next;
      blankRunHigh_reg  <= blankRunHigh_next;
      blankLowCarry_reg <= (blankRunLow_reg == BLANK_CARRY_AT);
    end
  end

  assign lnk.blankCount  = {blankRunHigh_reg, blankRunLow_reg};
  assign lnk.vblankFound = (lnk.blankCount == BLANK_FOUND_AT);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_blank_clear: assert property (
    !sampleZero |=> lnk.blankCount == '0)
    else $error("blank run not cleared by nonzero sample");
  a_blank_carry: assert property (
    (sampleZero && blankLowCarry_reg) |=>
      blankRunHigh_reg == BLANK_HI_W'($past(blankRunHigh_reg) + 3'h1))
    else $error("blank high stage missed carry");
endmodule : fbac_blank_run
`default_nettype wire

// ---- design/fbac_ctrl_fsm.sv ----
/*
  Control state machine: idle, sync wait, sample, display.
  Assumes captureMode is synchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module fbac_ctrl_fsm
  import fbac_pkg::*;
(
  // Clock and reset
  input wire logic  clk_sys,
  input wire logic  arst_n,
  // Mode request
  input wire logic  captureMode,
  // Memory and converter controls
  output logic      memWriteStrobe_n,
  output logic      memOutputStrobe_n,
  output logic      converterBufferOff,
  // Shared link
  fbac_link_if.ctrl lnk
);
  fbac_state_t state_reg;
  fbac_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (captureMode) state_next = ST_SYNC_WAIT;
      ST_SYNC_WAIT: if (lnk.vblankFound) state_next = ST_SAMPLE;
      ST_SAMPLE: if (lnk.frameEndFlag) state_next = ST_DISPLAY;
      ST_DISPLAY: if (!captureMode) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Decoded straight from the state, no output flops
  assign lnk.ctrlStateBits   = state_reg;
  assign lnk.addressAdvance  = (state_reg == ST_SAMPLE) ||
                               (state_reg == ST_DISPLAY);
  assign memWriteStrobe_n    = (state_reg != ST_SAMPLE);
  assign memOutputStrobe_n   = (state_reg != ST_DISPLAY);
  assign converterBufferOff  = (state_reg == ST_DISPLAY);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_sync_to_sample: assert property (
    (state_reg == ST_SYNC_WAIT && lnk.vblankFound) |=>
      (lnk.addressAdvance && !memWriteStrobe_n && memOutputStrobe_n))
    else $error("sampling not entered after vertical blank");
  a_end_to_display: assert property (
    (state_reg == ST_SAMPLE && lnk.frameEndFlag) |=>
      (memWriteStrobe_n && !memOutputStrobe_n && converterBufferOff))
    else $error("display strobes wrong after frame end");
  a_mode_release: assert property (
    (state_reg == ST_DISPLAY && !captureMode) |=>
      (!lnk.addressAdvance ##1 !lnk.addressAdvance))
    else $error("advance held after mode release");
endmodule : fbac_ctrl_fsm
`default_nettype wire

// ---- design/fbac_addr_counter.sv ----
/*
  Frame buffer address counter top: 18-bit sample address in two
  9-bit stages, end-of-frame flag, test preload, register port,
  blank-level run counter and control state machine.
  Assumes one 100 MHz clock and inputs synchronous to it.
*/
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - While advance is high the address steps by one each clock.
// - Address clears when advance is low or the last address passed.
// - Address is 18 bits in two cascaded 9-bit stages.
// - High stage steps only on low-stage carry, otherwise holds.
// - Every memory address bit comes straight from a flip-flop.
// - Memory strobes, buffer control, advance decode from state only.
// - Test preload input presets address bits on the clock edge.
// - Block takes the 8-bit converter sample bus as data input.
// - Blank run counter is 7 bits: 4-bit low, 3-bit high stage.
// - End-of-frame flag and stage carries are flip-flops.
// - End flag sets the clock after address equals the last address.
// - Low carry sets the clock after the low stage equals 510.
// - Preload forces address bits 17,16,15,14,12,11,10,8 high.
// - Advance high in sample and display, low in idle and sync wait.
module fbac_addr_counter
  import fbac_pkg::*;
(
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                arst_n,
  // Mode button and test preload
  input wire logic                captureMode,
  input wire logic                testPreload,
  // Converter samples
  input wire logic [SAMPLE_W-1:0] videoSample,
  // Register port
  input wire logic [REG_AW-1:0]   regAddr,
  input wire logic [REG_DW-1:0]   regWrData,
  input wire logic                regWrStb,
  input wire logic                regRdStb,
  output logic     [REG_DW-1:0]   regRdData,
  // Frame memory and converter
  output logic     [ADDR_W-1:0]   memAddr,
  output logic                    memWriteStrobe_n,
  output logic                    memOutputStrobe_n,
  output logic                    converterBufferOff,
  // Status pins
  output logic                    addressAdvance,
  output logic                    vblankFound,
  output logic                    frameEndFlag
);
  fbac_link_if lnk ();

  logic [STAGE_W-1:0] addrLowStage_reg;
  logic [STAGE_W-1:0] addrLowStage_next;
  logic [STAGE_W-1:0] addrHighStage_reg;
  logic [STAGE_W-1:0] addrHighStage_next;
  logic               addrLowCarry_reg;
  logic               frameEndFlag_reg;
  logic               swCapture_reg;
  logic [REG_DW-1:0]  regRdData_reg;
  logic [REG_DW-1:0]  regRdData_next;
  logic [REG_DW-1:0]  statusWord;

  wire logic               advanceRun;
  wire logic               captureEff;
  wire logic [ADDR_W-1:0]  fullAddr;
  wire logic [ADDR_W-1:0]  presetBits;
  wire logic [STAGE_W-1:0] lowStep;
  wire logic [STAGE_W-1:0] highStep;
  wire logic               wrCtrl;
  wire logic [REG_DW-1:0]  rdValue;

  function automatic logic regHit(
    input logic [REG_AW-1:0] addr,
    input logic [REG_AW-1:0] offset
  );
    return addr == offset;
  endfunction : regHit

  // Sub-blocks
  fbac_blank_run u_blank (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .videoSample (videoSample),
    .lnk         (lnk.blank)
  );

  fbac_ctrl_fsm u_ctrl (
    .clk_sys            (clk_sys),
    .arst_n             (arst_n),
    .captureMode        (captureEff),
    .memWriteStrobe_n   (memWriteStrobe_n),
    .memOutputStrobe_n  (memOutputStrobe_n),
    .converterBufferOff (converterBufferOff),
    .lnk                (lnk.ctrl)
  );

  // Button or software request starts a capture
  assign captureEff = captureMode | swCapture_reg;

  // Counting is gated off for the one clock after frame end
  assign advanceRun = lnk.addressAdvance && !frameEndFlag_reg;
  assign fullAddr   = {addrHighStage_reg, addrLowStage_reg};
  assign presetBits = testPreload ? PRESET_MASK : '0;

  assign lowStep  = STAGE_W'(addrLowStage_reg + 9'h1);
  assign highStep = STAGE_W'(addrHighStage_reg + 9'h1);

  // Preset is ORed onto the counted value, as a synchronous set
  assign addrLowStage_next =
    (advanceRun ? lowStep : '0) |
    presetBits[STAGE_W-1:0];
  assign addrHighStage_next =
    (!advanceRun      ? '0 :
     addrLowCarry_reg ? highStep : addrHighStage_reg) |
    presetBits[ADDR_W-1:STAGE_W];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addrLowStage_reg  <= '0;
      addrHighStage_reg <= '0;
    end else begin
      addrLowStage_reg  <= addrLowStage_next;
      addrHighStage_reg <= addrHighStage_next;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addrLowCarry_reg <= 1'b0;
      frameEndFlag_reg <= 1'b0;
    end else begin
      addrLowCarry_reg <= (addrLowStage_reg == LOW_CARRY_AT);
      frameEndFlag_reg <= (fullAddr == FRAME_LAST_ADDR);
    end
  end

  assign lnk.frameEndFlag = frameEndFlag_reg;

  // Register port
  assign wrCtrl = regWrStb && regHit(regAddr, REG_CTRL);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) swCapture_reg <= CTRL_RESET;
    else if (wrCtrl) swCapture_reg <= regWrData[CTRL_CAPTURE_BIT];
  end

  always_comb begin
    statusWord = '0;
    statusWord[STAT_STATE_LSB +: STATE_W] = lnk.ctrlStateBits;
    statusWord[STAT_END_BIT]              = frameEndFlag_reg;
    statusWord[STAT_VBLANK_BIT]           = lnk.vblankFound;
  end

  assign rdValue =
    regHit(regAddr, REG_CTRL)   ? REG_DW'(swCapture_reg) :
    regHit(regAddr, REG_STATUS) ? statusWord :
    regHit(regAddr, REG_ADDR)   ? REG_DW'(fullAddr) :
    regHit(regAddr, REG_BLANK)  ? REG_DW'(lnk.blankCount) :
    '0;
  assign regRdData_next = regRdStb ? rdValue : '0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) regRdData_reg <= '0;
    else regRdData_reg <= regRdData_next;
  end

  // Outputs
  assign regRdData          = regRdData_reg;
  assign memAddr            = fullAddr;
  assign frameEndFlag       = frameEndFlag_reg;
  assign addressAdvance     = lnk.addressAdvance;
  assign vblankFound        = lnk.vblankFound;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_runStep;
    lnk.addressAdvance && !frameEndFlag_reg && !testPreload;
  endsequence

  sequence s_nearWrap;
    addrLowStage_reg == LOW_CARRY_AT && lnk.addressAdvance &&
    !frameEndFlag_reg && !testPreload;
  endsequence

  sequence s_frameWrap;
    (frameEndFlag_reg && lnk.addressAdvance && !testPreload) ##1
    (lnk.addressAdvance && !frameEndFlag_reg && !testPreload);
  endsequence

  a_low_step: assert property (
    s_runStep |=>
      addrLowStage_reg == STAGE_W'($past(addrLowStage_reg) + 9'h1))
    else $error("low stage did not step while advancing");

  a_idle_clear: assert property (
    (!lnk.addressAdvance && !testPreload) |=> memAddr == '0)
    else $error("address not cleared without advance");

  a_end_clear: assert property (
    (frameEndFlag_reg && !testPreload) |=> memAddr == '0)
    else $error("address not cleared after frame end");

  a_high_hold: assert property (
    (lnk.addressAdvance && !frameEndFlag_reg && !testPreload &&
     !addrLowCarry_reg) |=> $stable(addrHighStage_reg))
    else $error("high stage moved without carry");

  a_high_step: assert property (
    (lnk.addressAdvance && !frameEndFlag_reg && !testPreload &&
     addrLowCarry_reg) |=>
      addrHighStage_reg == STAGE_W'($past(addrHighStage_reg) + 9'h1))
    else $error("high stage missed carry");

  a_carry_set: assert property (
    s_nearWrap |=> addrLowCarry_reg &&
      addrLowStage_reg == STAGE_W'(LOW_CARRY_AT + 9'h1))
    else $error("low carry not set one clock after 510");

  a_wrap_carry: assert property (
    s_nearWrap ##1 s_runStep |=>
      (addrLowStage_reg == '0 &&
       addrHighStage_reg == STAGE_W'($past(addrHighStage_reg, 2) + 9'h1)))
    else $error("high stage did not advance on low wrap");

  a_end_set: assert property (
    fullAddr == FRAME_LAST_ADDR |=> frameEndFlag_reg)
    else $error("frame end flag not set after last address");

  a_end_only: assert property (
    fullAddr != FRAME_LAST_ADDR |=> !frameEndFlag_reg)
    else $error("frame end flag set at wrong address");

  a_preset_bits: assert property (
    testPreload |=> (memAddr & PRESET_MASK) == PRESET_MASK)
    else $error("preload did not force preset bits");

  a_preset_sync: assert property (
    (testPreload && !lnk.addressAdvance) |=> memAddr == PRESET_MASK)
    else $error("preload value wrong without advance");

  a_resume_zero: assert property (
    s_frameWrap |=> memAddr == ADDR_W'(1))
    else $error("counting did not restart from zero");

  a_read_addr: assert property (
    (regRdStb && regHit(regAddr, REG_ADDR)) |=>
      regRdData == REG_DW'($past(fullAddr)))
    else $error("address register read wrong");

  a_read_idle: assert property (
    !regRdStb |=> regRdData == '0)
    else $error("read data not zero outside read cycle");

  a_ctrl_write: assert property (
    wrCtrl |=> swCapture_reg == $past(regWrData[CTRL_CAPTURE_BIT]))
    else $error("capture control bit not written");
endmodule : fbac_addr_counter
`default_nettype wire

// ---- tb/fbac_sram_model.sv ----
/*
  Behavioural frame buffer memory and video converter at the far side
  of the address counter. Assumes one clock, clk_sys, and a bench that
  picks the converter level.
*/
`timescale 1ns/100ps
`default_nettype none
module fbac_sram_model
  import fbac_pkg::*;
(
  // Clock
  input  wire logic                clk_sys,
  // Memory controls from the block
  input  wire logic [ADDR_W-1:0]   memAddr,
  input  wire logic                memWriteStrobe_n,
  input  wire logic                memOutputStrobe_n,
  // Converter level chosen by the bench
  input  wire logic [SAMPLE_W-1:0] sampleLevel,
  // Converter samples and memory read data
  output logic     [SAMPLE_W-1:0]  videoSample,
  output logic     [SAMPLE_W-1:0]  ramData
);
  logic [SAMPLE_W-1:0] memArray [0:(1<<ADDR_W)-1];
  logic [SAMPLE_W-1:0] lastData_reg;

  assign videoSample = sampleLevel;

  always_ff @(posedge clk_sys) begin
    if (!memWriteStrobe_n) begin
      memArray[memAddr] <= videoSample;
    end
    if (!memOutputStrobe_n) begin
      lastData_reg <= memArray[memAddr];
    end
  end

  // Released bus shows the inverse of the last value
  assign ramData = !memOutputStrobe_n ? memArray[memAddr] : ~lastData_reg;
endmodule : fbac_sram_model
`default_nettype wire

// ---- tb/fbac_addr_counter_bench.sv ----
/*
  Self-checking bench for the frame buffer address counter.
  Assumes the memory and converter model in fbac_sram_model.
*/
`timescale 1ns/100ps
`default_nettype none
module fbac_addr_counter_bench
  import fbac_pkg::*;
;
  logic                clk_sys;
  logic                arst_n;
  logic                captureMode;
  logic                testPreload;
  logic [SAMPLE_W-1:0] videoSample;
  logic [SAMPLE_W-1:0] sampleLevel;
  logic [SAMPLE_W-1:0] ramData;
  logic [REG_AW-1:0]   regAddr;
  logic [REG_DW-1:0]   regWrData;
  logic                regWrStb;
  logic                regRdStb;
  logic [REG_DW-1:0]   regRdData;
  logic [ADDR_W-1:0]   memAddr;
  logic                memWriteStrobe_n;
  logic                memOutputStrobe_n;
  logic                converterBufferOff;
  logic                addressAdvance;
  logic                vblankFound;
  logic                frameEndFlag;
  logic [3:0]          ctlBits;
  int                  nFail = 0;
  int                  cmpCount = 0;
  int                  cycleCount = 0;

  assign ctlBits = {memWriteStrobe_n, memOutputStrobe_n,
                    converterBufferOff, addressAdvance};

  fbac_addr_counter dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .captureMode(captureMode),
    .testPreload(testPreload), .videoSample(videoSample),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .memAddr(memAddr),
    .memWriteStrobe_n(memWriteStrobe_n),
    .memOutputStrobe_n(memOutputStrobe_n),
    .converterBufferOff(converterBufferOff),
    .addressAdvance(addressAdvance), .vblankFound(vblankFound),
    .frameEndFlag(frameEndFlag)
  );

  fbac_sram_model partner (
    .clk_sys(clk_sys), .memAddr(memAddr),
    .memWriteStrobe_n(memWriteStrobe_n),
    .memOutputStrobe_n(memOutputStrobe_n), .sampleLevel(sampleLevel),
    .videoSample(videoSample), .ramData(ramData)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    cmpCount++;
    if (seen !== expv) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  task automatic step();
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : step

  task automatic reg_wr(input logic [REG_AW-1:0] a,
                        input logic [REG_DW-1:0] d);
    @(posedge clk_sys);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrStb  <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [REG_AW-1:0] a,
                         input logic [REG_DW-1:0] expv);
    @(posedge clk_sys);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    @(negedge clk_sys);
    chk(regRdData, expv);
  endtask : reg_chk

  task automatic s_reset();
    @(negedge clk_sys);
    chk(32'(memAddr), 32'h0);
    chk(32'(frameEndFlag), 32'h0);
    chk(32'(ctlBits), 32'hc);
    reg_chk(REG_STATUS, 32'h00000001);
    reg_chk(8'h10, 32'h0);
  endtask : s_reset

  // Zero run broken once, then counted until the blank level is found
  task automatic s_vblank();
    int n;
    @(posedge clk_sys);
    captureMode <= 1'b1;
    sampleLevel <= 8'h00;
    repeat (60) @(posedge clk_sys);
    sampleLevel <= 8'h3c;
    @(posedge clk_sys);
    sampleLevel <= 8'h00;
    @(negedge clk_sys);
    n = 0;
    while (vblankFound !== 1'b1 && n < 300) begin
      step();
      n++;
    end
    chk(n, 127);
    chk(32'(ctlBits), 32'hc);
    chk(32'(memAddr), 32'h0);
    @(posedge clk_sys);
    sampleLevel <= 8'h3c;
    @(negedge clk_sys);
    chk(32'(ctlBits), 32'h5);
    chk(32'(memAddr), 32'h0);
  endtask : s_vblank

  // Two low-stage wraps, preload, then run to the end of the frame
  task automatic s_count();
    logic [31:0] a;
    for (a = 32'h1; a <= 32'h3ff; a++) begin
      step();
      chk(32'(memAddr), a);
    end
    @(posedge clk_sys);
    testPreload <= 1'b1;
    @(negedge clk_sys);
    chk(32'(memAddr), 32'h400);
    @(posedge clk_sys);
    testPreload <= 1'b0;
    @(negedge clk_sys);
    chk(32'(memAddr), 32'h3dd01);
    for (a = 32'h3dd02; a <= 32'h3dd3c; a++) begin
      step();
      chk(32'(memAddr), a);
      chk(32'(frameEndFlag), 32'(a == 32'h3dd3c));
    end
    step();
    chk(32'(memAddr), 32'h0);
    chk(32'(ctlBits), 32'hb);
    step();
    chk(32'(memAddr), 32'h1);
    chk(32'(ramData), 32'h3c);
    reg_chk(REG_STATUS, 32'h00000008);
    reg_chk(REG_BLANK, 32'h0);
  endtask : s_count

  task automatic s_idle();
    @(posedge clk_sys);
    captureMode <= 1'b0;
    step();
    chk(32'(ctlBits), 32'hc);
    // Display still advanced at the leaving edge; clears one edge later
    step();
    chk(32'(memAddr), 32'h0);
    reg_wr(REG_CTRL, 32'h1);
    reg_chk(REG_CTRL, 32'h1);
    reg_chk(REG_STATUS, 32'h00000002);
    @(posedge clk_sys);
    testPreload <= 1'b1;
    @(posedge clk_sys);
    testPreload <= 1'b0;
    @(negedge clk_sys);
    chk(32'(memAddr), 32'h3dd00);
    step();
    chk(32'(memAddr), 32'h0);
    reg_wr(REG_ADDR, 32'h3ffff);
    reg_chk(REG_ADDR, 32'h0);
    reg_wr(REG_CTRL, 32'h0);
  endtask : s_idle

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycleCount = cycleCount + 1;
    if (cycleCount == 20000) begin
      nFail++;
      final_report();
    end
  end

  initial begin
    arst_n      = 1'b0;
    captureMode = 1'b0;
    testPreload = 1'b0;
    sampleLevel = 8'h3c;
    regAddr     = 8'h00;
    regWrData   = 32'h0;
    regWrStb    = 1'b0;
    regRdStb    = 1'b0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    s_reset();
    s_vblank();
    s_count();
    s_idle();
    final_report();
  end
endmodule : fbac_addr_counter_bench
`default_nettype wire
